// *** core/indirect_table_access.sv ***
`timescale 1ns/1ps
`include "indirect_table_consts.svh"


module indirect_table_access (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o,
	input wire logic [63:0] cnt_evt_i,
	input wire logic [3:0] drop_evt_i,
	input wire logic lkp_req_i,
	input wire logic lkp_sa_i,
	input wire logic [47:0] lkp_mac_i,
	input wire logic [3:0] lkp_fid_i,
	input wire logic [1:0] ingress_port_i,
	input wire logic dyn_hit_i,
	input wire logic [2:0] dyn_ports_i,
	output logic fwd_valid_o,
	output logic fwd_hit_o,
	output logic fwd_static_o,
	output logic [2:0] fwd_ports_o,
	output logic fwd_override_o
);
	// --------------------------------
	// state
	// --------------------------------
	indirect_table_pkg::acc_state_t state_ff;
	indirect_table_pkg::acc_state_t nxt_state;
	logic [12:0] ctl_ff;
	logic launch_ff;
	logic [15:0] low_ff;
	logic [15:0] upr_ff;
	logic [15:0] mid_ff;
	logic [9:0] top_ff;
	logic [15:0] rdata_ff;
	logic fwd_valid_ff;
	logic fwd_hit_ff;
	logic fwd_static_ff;
	logic [2:0] fwd_ports_ff;
	logic fwd_override_ff;

	// sub-block results
	logic [31:0] cnt_rdata;
	logic cnt_done;
	indirect_table_pkg::static_entry_t st_rdata;
	logic st_done;
	logic st_hit;
	logic [2:0] st_ports;
	logic st_ovr;

	// --------------------------------
	// host port decode
	// --------------------------------
	wire wr_ctl = reg_wr_i & (reg_addr_i == `OFS_CTL);
	wire wr_low = reg_wr_i & (reg_addr_i == `OFS_LOW);
	wire wr_upr = reg_wr_i & (reg_addr_i == `OFS_UPR);
	wire wr_mid = reg_wr_i & (reg_addr_i == `OFS_MID);
	wire wr_top = reg_wr_i & (reg_addr_i == `OFS_TOP);
	wire [1:0] new_sel = reg_wdata_i[`CTL_SEL_HI:`CTL_SEL_LO];
	wire new_rd = reg_wdata_i[`CTL_RD];

	// counters are read-only and other tables live elsewhere, so those codes are dropped
	wire cmd_ok = (new_sel == `SEL_STATIC) | ((new_sel == `SEL_COUNTER) & new_rd);
	wire idle = (state_ff == indirect_table_pkg::ST_IDLE);
	wire start = wr_ctl & cmd_ok & idle;

	// --------------------------------
	// latched command fields
	// --------------------------------
	wire cur_rd = ctl_ff[`CTL_RD];
	wire [1:0] cur_sel = ctl_ff[`CTL_SEL_HI:`CTL_SEL_LO];
	wire [9:0] cur_idx = ctl_ff[9:0];
	wire is_cnt = (cur_sel == `SEL_COUNTER);
	wire is_st = (cur_sel == `SEL_STATIC);
	wire cnt_rd = launch_ff & is_cnt;
	wire st_rd = launch_ff & is_st & cur_rd;
	wire st_wr = launch_ff & is_st & !cur_rd;
	wire done = cnt_done | st_done;
	wire pp_idx = (cur_idx <= `PP_LAST);

	// write data gathered from the four words, loaded beforehand by the host
	wire [57:0] st_wdata = {top_ff, mid_ff, upr_ff, low_ff};

	// --------------------------------
	// sequencer
	// --------------------------------
	// a control write while busy is ignored so the pending command is not corrupted
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			indirect_table_pkg::ST_IDLE: begin
				if (start) begin
					nxt_state = indirect_table_pkg::ST_BUSY;
				end
			end
			indirect_table_pkg::ST_BUSY: begin
				if (done) begin
					nxt_state = indirect_table_pkg::ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			state_ff <= indirect_table_pkg::ST_IDLE;
			launch_ff <= 1'b0;
			ctl_ff <= 13'h0;
		end else begin
			state_ff <= nxt_state;
			launch_ff <= start;
			if (start) begin
				ctl_ff <= reg_wdata_i[12:0];
			end
		end
	end

	// --------------------------------
	// indirect data words
	// --------------------------------
	// a finished read overwrites the words it returns (only LOW and UPR for a counter); the host must not load them meanwhile
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			low_ff <= 16'h0;
			upr_ff <= 16'h0;
			mid_ff <= 16'h0;
			top_ff <= 10'h0;
		end else if (cnt_done) begin
			low_ff <= cnt_rdata[15:0];
			upr_ff <= cnt_rdata[31:16];
		end else if (st_done && cur_rd) begin
			low_ff <= st_rdata[15:0];
			upr_ff <= st_rdata[31:16];
			mid_ff <= st_rdata[47:32];
			top_ff <= st_rdata[57:48];
		end else begin
			if (wr_low) begin
				low_ff <= reg_wdata_i;
			end
			if (wr_upr) begin
				upr_ff <= reg_wdata_i;
			end else if (cnt_rd) begin
				upr_ff[`UPR_VALID] <= 1'b0;
			end
			if (wr_mid) begin
				mid_ff <= reg_wdata_i;
			end
			if (wr_top) begin
				top_ff <= reg_wdata_i[9:0];
			end
		end
	end

	// --------------------------------
	// read data mux, registered
	// --------------------------------
	wire [15:0] ctl_view = {~idle, 2'b00, ctl_ff};
	wire [15:0] rd_mux = (reg_addr_i == `OFS_CTL) ? ctl_view :
		(reg_addr_i == `OFS_LOW) ? low_ff :
		(reg_addr_i == `OFS_UPR) ? upr_ff :
		(reg_addr_i == `OFS_MID) ? mid_ff :
		(reg_addr_i == `OFS_TOP) ? {6'h00, top_ff} : 16'h0000;

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			rdata_ff <= 16'h0;
		end else if (reg_rd_i) begin
			rdata_ff <= rd_mux;
		end
	end

	// --------------------------------
	// sub-blocks
	// --------------------------------
	mib_counter_bank u_cnt (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.cnt_evt_i(cnt_evt_i),
		.drop_evt_i(drop_evt_i),
		.rd_i(cnt_rd),
		.idx_i(cur_idx),
		.rdata_o(cnt_rdata),
		.done_o(cnt_done)
	);

	static_mac_table u_st (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.wr_i(st_wr),
		.rd_i(st_rd),
		.idx_i(cur_idx[2:0]),
		.wdata_i(st_wdata),
		.rdata_o(st_rdata),
		.done_o(st_done),
		.lkp_mac_i(lkp_mac_i),
		.lkp_fid_i(lkp_fid_i),
		.hit_o(st_hit),
		.ports_o(st_ports),
		.ovr_o(st_ovr)
	);

	// --------------------------------
	// forwarding decision
	// --------------------------------
	// source lookups serve learning only, so the static table is not consulted
	wire use_st = st_hit & !lkp_sa_i;
	wire [2:0] ing_mask = 3'(3'h1 << ingress_port_i);
	wire [2:0] st_fwd = (st_ports == `FWD_BCAST) ? (st_ports & ~ing_mask) : st_ports;
	wire [2:0] sel_ports = use_st ? st_fwd : (dyn_hit_i ? dyn_ports_i : 3'h0);

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			fwd_valid_ff <= 1'b0;
			fwd_hit_ff <= 1'b0;
			fwd_static_ff <= 1'b0;
			fwd_ports_ff <= 3'h0;
			fwd_override_ff <= 1'b0;
		end else begin
			fwd_valid_ff <= lkp_req_i;
			if (lkp_req_i) begin
				fwd_hit_ff <= use_st | dyn_hit_i;
				fwd_static_ff <= use_st;
				fwd_ports_ff <= sel_ports;
				fwd_override_ff <= use_st & st_ovr;
			end
		end
	end

	// outputs straight from flops
	assign reg_rdata_o = rdata_ff;
	assign fwd_valid_o = fwd_valid_ff;
	assign fwd_hit_o = fwd_hit_ff;
	assign fwd_static_o = fwd_static_ff;
	assign fwd_ports_o = fwd_ports_ff;
	assign fwd_override_o = fwd_override_ff;

	// --------------------------------
	// checks
	// --------------------------------
	ctl_launch_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		start |=> launch_ff && !idle ##1 !launch_ff)
		else $error("control write did not launch one access");

	valid_clear_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		cnt_rd && !wr_upr |=> !upr_ff[`UPR_VALID] ##1 upr_ff[`UPR_VALID] == (cur_idx <= `PP_LAST))
		else $error("valid flag sequence wrong on counter read");

	cnt_done_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		start && new_sel == `SEL_COUNTER |-> ##2 cnt_done ##1 idle)
		else $error("counter read did not finish in two cycles");

	drop_word_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		cnt_done && !pp_idx |=> upr_ff == 16'h0000)
		else $error("dropped counter upper bits not zero");

	ovf_flag_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		cnt_done && pp_idx |=> upr_ff[`UPR_OVF] == $past(cnt_rdata[31]))
		else $error("overflow flag not passed to upper word");

	static_prec_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		lkp_req_i && st_hit && !lkp_sa_i |=> fwd_static_o && fwd_ports_o == $past(st_fwd))
		else $error("static hit did not take precedence");

	sa_dyn_only_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		lkp_req_i && lkp_sa_i |=> !fwd_static_o && !fwd_override_o)
		else $error("source lookup used the static table");

	bcast_excl_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		lkp_req_i && use_st && st_ports == `FWD_BCAST |=> (fwd_ports_o & $past(ing_mask)) == 3'h0)
		else $error("broadcast included the ingress port");

	st_commit_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		start && new_sel == `SEL_STATIC && !new_rd |-> ##1 st_wr ##1 st_done ##1 idle)
		else $error("static write did not commit in two cycles");
endmodule

// *** core/mib_counter_bank.sv ***
`timescale 1ns/1ps
`include "indirect_table_consts.svh"

module mib_counter_bank (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [63:0] cnt_evt_i,
	input wire logic [3:0] drop_evt_i,
	input wire logic rd_i,
	input wire logic [9:0] idx_i,
	output logic [31:0] rdata_o,
	output logic done_o
);
	// per-port: bit 30 overflow, 29..0 count
	logic [30:0] cnt_ff [0:63];
	logic [15:0] drop_ff [0:3];

	// --------------------------------
	// address decode
	// --------------------------------
	wire pp_hit = (idx_i <= `PP_LAST);
	wire drop_hit = (idx_i == `TXDROP_P1) | (idx_i == `TXDROP_P2) |
		(idx_i == `RXDROP_P1) | (idx_i == `RXDROP_P2);
	wire [1:0] drop_sel = (idx_i == `TXDROP_P1) ? 2'h0 :
		(idx_i == `TXDROP_P2) ? 2'h1 :
		(idx_i == `RXDROP_P1) ? 2'h2 : 2'h3;

	// --------------------------------
	// per-port counters, cleared by their own read
	// --------------------------------
	genvar i;
	generate
		for (i = 0; i < 64; i++) begin : g_pp
			wire clr = rd_i & pp_hit & (idx_i[5:0] == 6'(i));
			// an event in the clearing cycle is kept as the new first count
			always_ff @(posedge sys_clk_i) begin
				if (!rst_n_i) begin
					cnt_ff[i] <= 31'h0;
				end else if (clr) begin
					cnt_ff[i] <= {30'h0, cnt_evt_i[i]};
				end else if (cnt_evt_i[i]) begin
					cnt_ff[i] <= {cnt_ff[i][30] | (&cnt_ff[i][29:0]), cnt_ff[i][29:0] + 30'h1};
				end
			end
		end
		// dropped-frame counters simply wrap; reads leave them alone
		for (i = 0; i < 4; i++) begin : g_drop
			always_ff @(posedge sys_clk_i) begin
				if (!rst_n_i) begin
					drop_ff[i] <= 16'h0;
				end else if (drop_evt_i[i]) begin
					drop_ff[i] <= drop_ff[i] + 16'h1;
				end
			end
		end
	endgenerate

	// --------------------------------
	// read snapshot, one cycle after the strobe
	// --------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			rdata_o <= 32'h0;
			done_o <= 1'b0;
		end else begin
			done_o <= rd_i;
			if (rd_i) begin
				rdata_o <= pp_hit ? {cnt_ff[idx_i[5:0]][30], 1'b1, cnt_ff[idx_i[5:0]][29:0]} :
					drop_hit ? {16'h0, drop_ff[drop_sel]} : 32'h0;
			end
		end
	end

	// a read with no event in the same cycle leaves a zero count
	rd_clear_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		rd_i && pp_hit && !cnt_evt_i[idx_i[5:0]] |=> cnt_ff[$past(idx_i[5:0])] == 31'h0)
		else $error("per-port counter not cleared by read");
endmodule

// *** core/static_mac_table.sv ***
`timescale 1ns/1ps
`include "indirect_table_consts.svh"

module static_mac_table (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [2:0] idx_i,
	input wire indirect_table_pkg::static_entry_t wdata_i,
	output indirect_table_pkg::static_entry_t rdata_o,
	output logic done_o,
	input wire logic [47:0] lkp_mac_i,
	input wire logic [3:0] lkp_fid_i,
	output logic hit_o,
	output logic [2:0] ports_o,
	output logic ovr_o
);
	indirect_table_pkg::static_entry_t ent_ff [0:7];
	logic [7:0] match;
	logic [2:0] sel;

	// --------------------------------
	// entries and per-entry match
	// --------------------------------
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_ent
			// only a host write changes an entry: nothing ages it out
			always_ff @(posedge sys_clk_i) begin
				if (!rst_n_i) begin
					ent_ff[i] <= 58'h0;
				end else if (wr_i && idx_i == 3'(i)) begin
					ent_ff[i] <= wdata_i;
				end
			end
			assign match[i] = ent_ff[i][`ST_VALID] &
				(ent_ff[i][`ST_MAC_HI:0] == lkp_mac_i) &
				(!ent_ff[i][`ST_MATCH_WITH_GROUP_IDENTIFIER] | (ent_ff[i][`ST_FID_HI:`ST_FID_LO] == lkp_fid_i));
		end
	endgenerate

	// lowest matching index wins when several entries overlap
	always_comb begin
		sel = 3'h0;
		for (int k = 7; k >= 0; k--) begin
			if (match[k]) begin
				sel = 3'(k);
			end
		end
	end

	assign hit_o = |match;
	assign ports_o = ent_ff[sel][`ST_FWD_HI:`ST_FWD_LO];
	assign ovr_o = ent_ff[sel][`ST_OVR];

	// --------------------------------
	// host read port
	// --------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			rdata_o <= 58'h0;
			done_o <= 1'b0;
		end else begin
			done_o <= rd_i | wr_i;
			if (rd_i) begin
				rdata_o <= ent_ff[idx_i];
			end
		end
	end

	invalid_no_hit_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		hit_o |-> ent_ff[sel][`ST_VALID])
		else $error("lookup hit on an invalid entry");
endmodule

// *** pkg/indirect_table_consts.svh ***
`ifndef INDIRECT_TABLE_CONSTS_SVH
`define INDIRECT_TABLE_CONSTS_SVH

// --------------------------------
// register offsets on the host port
// --------------------------------
`define OFS_CTL 4'h0
`define OFS_LOW 4'h1
`define OFS_UPR 4'h2
`define OFS_MID 4'h3
`define OFS_TOP 4'h4

// --------------------------------
// control word layout and codes
// --------------------------------
`define CTL_RD 12
`define CTL_SEL_HI 11
`define CTL_SEL_LO 10
`define CTL_BUSY 15
`define SEL_STATIC 2'h0
`define SEL_COUNTER 2'h3

// --------------------------------
// counter address map and word layout
// --------------------------------
`define PP_LAST 10'h03F
`define TXDROP_P1 10'h100
`define TXDROP_P2 10'h101
`define RXDROP_P1 10'h103
`define RXDROP_P2 10'h104
`define UPR_OVF 15
`define UPR_VALID 14

// --------------------------------
// static entry layout
// --------------------------------
`define ST_FID_HI 57
`define ST_FID_LO 54
`define ST_MATCH_WITH_GROUP_IDENTIFIER 53
`define ST_OVR 52
`define ST_VALID 51
`define ST_FWD_HI 50
`define ST_FWD_LO 48
`define ST_MAC_HI 47
`define FWD_BCAST 3'h7

`endif

// *** pkg/indirect_table_pkg.sv ***
package indirect_table_pkg;
	// access sequencer states
	typedef enum logic {ST_IDLE, ST_BUSY} acc_state_t;
	// one static forwarding entry, bits 57..0
	typedef logic [57:0] static_entry_t;
endpackage

// *** tb/tb_indirect_table_access.sv ***
`timescale 1ns/1ps
`include "indirect_table_consts.svh"

module tb_indirect_table_access;
	logic sys_clk_i;
	logic rst_n_i;
	logic [3:0] reg_addr_i;
	logic [15:0] reg_wdata_i;
	logic reg_wr_i;
	logic reg_rd_i;
	logic [15:0] reg_rdata_o;
	logic [63:0] cnt_evt_i;
	logic [3:0] drop_evt_i;
	logic lkp_req_i;
	logic lkp_sa_i;
	logic [47:0] lkp_mac_i;
	logic [3:0] lkp_fid_i;
	logic [1:0] ingress_port_i;
	logic dyn_hit_i;
	logic [2:0] dyn_ports_i;
	logic fwd_valid_o;
	logic fwd_hit_o;
	logic fwd_static_o;
	logic [2:0] fwd_ports_o;
	logic fwd_override_o;
	integer err_count;
	integer n_compared;
	logic [15:0] d;
	logic [9:0] drop_ofs [4];
	indirect_table_pkg::static_entry_t e7, e2, e3;

	indirect_table_access DUT (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.cnt_evt_i(cnt_evt_i), .drop_evt_i(drop_evt_i), .lkp_req_i(lkp_req_i), .lkp_sa_i(lkp_sa_i),
		.lkp_mac_i(lkp_mac_i), .lkp_fid_i(lkp_fid_i), .ingress_port_i(ingress_port_i), .dyn_hit_i(dyn_hit_i),
		.dyn_ports_i(dyn_ports_i), .fwd_valid_o(fwd_valid_o), .fwd_hit_o(fwd_hit_o),
		.fwd_static_o(fwd_static_o), .fwd_ports_o(fwd_ports_o), .fwd_override_o(fwd_override_o));

	// --------------------------------
	// clock and watchdog
	// --------------------------------
	// 25 MHz system clock
	initial begin
		sys_clk_i = 1'h0;
		forever #20 sys_clk_i = ~sys_clk_i;
	end

	// the whole run needs well under 3000 cycles, so 20000 means a hang
	initial begin
		#(40 * 20000);
		err_count = err_count + 1;
		print_verdict();
	end

	// --------------------------------
	// shared tasks
	// --------------------------------
	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		n_compared = n_compared + 1;
		if (seen !== exp) begin
			err_count = err_count + 1;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("compared %0d values, %0d mismatches", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// strobe lowered one edge later, so back-to-back calls never touch it twice in one step
	task automatic reg_write(input logic [3:0] a, input logic [15:0] v);
		@(posedge sys_clk_i);
		reg_wr_i <= 1'h1;
		reg_addr_i <= a;
		reg_wdata_i <= v;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'h0;
	endtask

	// read data stand from the cycle after the strobe and hold until the next read strobe
	task automatic reg_read(input logic [3:0] a, output logic [15:0] v);
		@(posedge sys_clk_i);
		reg_rd_i <= 1'h1;
		reg_addr_i <= a;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'h0;
		#1 v = reg_rdata_o;
	endtask

	// launch an access and poll busy with a bounded count
	task automatic ctl_cmd(input logic [15:0] c);
		int n;
		reg_write(`OFS_CTL, c);
		n = 0;
		reg_read(`OFS_CTL, d);
		while (d[`CTL_BUSY] !== 1'h0 && n < 8) begin
			n = n + 1;
			reg_read(`OFS_CTL, d);
		end
		check("busy clears", d[`CTL_BUSY], 1'h0);
	endtask

	task automatic cnt_chk(input logic [9:0] idx, input logic [15:0] up, input logic [15:0] lo);
		logic [15:0] u;
		logic [15:0] l;
		int n;
		ctl_cmd(16'h1C00 | {6'h00, idx});
		reg_read(`OFS_UPR, u);
		n = 0;
		// per-port words: upper first, reread while the valid flag is still down
		while (idx <= `PP_LAST && u[`UPR_VALID] !== 1'h1 && n < 8) begin
			n = n + 1;
			reg_read(`OFS_UPR, u);
		end
		reg_read(`OFS_LOW, l);
		check("counter upper", u, up);
		check("counter low", l, lo);
	endtask

	task automatic evt(input int n, input int times, input logic drop);
		for (int i = 0; i < times; i++) begin
			@(posedge sys_clk_i);
			if (drop) drop_evt_i <= 4'h1 << n;
			else cnt_evt_i <= 64'h1 << n;
			@(posedge sys_clk_i);
			drop_evt_i <= 4'h0;
			cnt_evt_i <= 64'h0;
		end
	endtask

	task automatic st_write(input logic [2:0] idx, input indirect_table_pkg::static_entry_t e);
		reg_write(`OFS_TOP, {6'h00, e[57:48]});
		reg_write(`OFS_MID, e[47:32]);
		reg_write(`OFS_UPR, e[31:16]);
		reg_write(`OFS_LOW, e[15:0]);
		ctl_cmd({13'h0000, idx});
	endtask

	task automatic st_chk(input logic [2:0] idx, input indirect_table_pkg::static_entry_t exp);
		logic [15:0] t, m, u, l;
		ctl_cmd(16'h1000 | {13'h0000, idx});
		reg_read(`OFS_TOP, t);
		reg_read(`OFS_MID, m);
		reg_read(`OFS_UPR, u);
		reg_read(`OFS_LOW, l);
		check("static entry", {t[9:0], m, u, l}, exp);
	endtask

	// result layout: valid, hit, static, override, ports
	task automatic lookup(input logic sa, input logic [47:0] mac, input logic [3:0] filter_group_identifier, input logic [1:0] ing,
		input logic dh, input logic [2:0] dp, input logic [6:0] exp);
		@(posedge sys_clk_i);
		lkp_req_i <= 1'h1;
		lkp_sa_i <= sa;
		lkp_mac_i <= mac;
		lkp_fid_i <= filter_group_identifier;
		ingress_port_i <= ing;
		dyn_hit_i <= dh;
		dyn_ports_i <= dp;
		@(posedge sys_clk_i);
		lkp_req_i <= 1'h0;
		#1 check("lookup", {fwd_valid_o, fwd_hit_o, fwd_static_o, fwd_override_o, fwd_ports_o}, exp);
	endtask

	// --------------------------------
	// main sequence
	// --------------------------------
	initial begin
		err_count = 0;
		n_compared = 0;
		rst_n_i = 1'h0;
		{reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i} = '0;
		{cnt_evt_i, drop_evt_i, lkp_req_i, lkp_sa_i, lkp_mac_i, lkp_fid_i} = '0;
		{ingress_port_i, dyn_hit_i, dyn_ports_i} = '0;
		drop_ofs = '{`TXDROP_P1, `TXDROP_P2, `RXDROP_P1, `RXDROP_P2};
		e7 = {4'h5, 1'h1, 1'h1, 1'h1, 3'h7, 48'hA1B2_C3D4_E5F6};
		e2 = {4'h0, 1'h0, 1'h0, 1'h1, 3'h0, 48'h0000_1111_2222};
		e3 = {4'h9, 1'h0, 1'h0, 1'h1, 3'h5, 48'h0000_3333_4444};
		repeat (3) @(posedge sys_clk_i);
		rst_n_i <= 1'h1;

		// reset values and an unmapped offset
		reg_read(`OFS_CTL, d);
		check("control after reset", d, 16'h0000);
		reg_write(4'h9, 16'hFFFF);
		reg_read(4'h9, d);
		check("unmapped offset", d, 16'h0000);
		st_chk(3'h1, '0);
		$display("test reset done");

		// per-port counters: read, read-clear, both ports, last offset
		evt(14, 5, 1'h0);
		cnt_chk(10'h00E, 16'h4000, 16'h0005);
		cnt_chk(10'h00E, 16'h4000, 16'h0000);
		// upper word read while the access is still running shows the valid flag down
		reg_write(`OFS_CTL, 16'h1C0E);
		reg_read(`OFS_UPR, d);
		check("valid while busy", d[`UPR_VALID], 1'h0);
		reg_read(`OFS_UPR, d);
		check("valid after busy", d, 16'h4000);
		// a second control write while busy must not replace the pending command
		reg_write(`OFS_CTL, 16'h1C0E);
		reg_write(`OFS_CTL, 16'h1C2E);
		reg_read(`OFS_CTL, d);
		check("busy write ignored", d, 16'h1C0E);
		evt(46, 3, 1'h0);
		evt(63, 1, 1'h0);
		cnt_chk(10'h02E, 16'h4000, 16'h0003);
		cnt_chk(10'h03F, 16'h4000, 16'h0001);
		reg_read(`OFS_CTL, d);
		check("control readback", d, 16'h1C3F);
		reg_write(`OFS_CTL, 16'h1403);
		reg_write(`OFS_CTL, 16'h0C05);
		reg_read(`OFS_CTL, d);
		check("refused control", d, 16'h1C3F);
		reg_read(`OFS_UPR, d);
		check("no overflow", d[`UPR_OVF], 1'h0);
		$display("test per-port counters done");

		// dropped-frame counters keep their value; the gap offset reads zero
		for (int i = 0; i < 4; i++) begin
			evt(i, i + 2, 1'h1);
		end
		for (int i = 0; i < 4; i++) begin
			cnt_chk(drop_ofs[i], 16'h0000, 16'(i + 2));
			cnt_chk(drop_ofs[i], 16'h0000, 16'(i + 2));
		end
		cnt_chk(10'h102, 16'h0000, 16'h0000);
		$display("test dropped counters done");

		// static table write then read back
		st_write(3'h7, e7);
		st_write(3'h2, e2);
		st_write(3'h3, e3);
		st_chk(3'h7, e7);
		st_chk(3'h2, e2);
		st_chk(3'h0, '0);
		$display("test static table done");

		// lookups: precedence, group match, source lookup, drop, invalid entries
		lookup(1'h0, 48'hA1B2_C3D4_E5F6, 4'h5, 2'h1, 1'h1, 3'h1, 7'h7D);
		lookup(1'h0, 48'hA1B2_C3D4_E5F6, 4'h6, 2'h1, 1'h1, 3'h2, 7'h62);
		lookup(1'h1, 48'hA1B2_C3D4_E5F6, 4'h5, 2'h0, 1'h1, 3'h2, 7'h62);
		lookup(1'h0, 48'h0000_3333_4444, 4'h2, 2'h0, 1'h0, 3'h0, 7'h75);
		lookup(1'h0, 48'h0000_1111_2222, 4'h0, 2'h0, 1'h1, 3'h4, 7'h70);
		lookup(1'h0, 48'h0000_0000_0000, 4'h0, 2'h0, 1'h0, 3'h0, 7'h40);
		repeat (50) @(posedge sys_clk_i);
		lookup(1'h0, 48'hA1B2_C3D4_E5F6, 4'h5, 2'h2, 1'h0, 3'h0, 7'h7B);
		$display("test lookups done");
		print_verdict();
	end
endmodule
